// ---- rtl/pmcs_pkg.sv ----
// power mode clock sequencer: shared constants, types and layouts
// assumes one 25 MHz oscillator clock; subclock arrives as a one-cycle tick
package pmcs_pkg;

   localparam int CLK_HZ = 25000000;
   localparam int NUM_MODULES = 8;
   localparam int PRESC_W = 13;
   localparam int WAIT_W = 13;
   localparam int ADDR_W = 4;

   // register offsets
   localparam logic [3:0] ADDR_CTRL1 = 4'h0;
   localparam logic [3:0] ADDR_CTRL2 = 4'h1;
   localparam logic [3:0] ADDR_MSTOP = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;

   // system_control_one fields
   localparam int DEEP_SLEEP_BIT = 7;
   localparam int WAIT_SEL_HI = 6;
   localparam int WAIT_SEL_LO = 4;
   localparam int WAKE_CLK_BIT = 3;
   localparam int MED_DIV_HI = 1;
   localparam int MED_DIV_LO = 0;

   // system_control_reg fields
   localparam int SUB_DIV_HI = 1;
   localparam int SUB_DIV_LO = 0;
   localparam int MEDIUM_BIT = 2;
   localparam int WATCH_KEEP_BIT = 3;

   // reset values
   localparam logic [7:0] CTRL1_RST = 8'h03;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] MSTOP_RST = 8'h00;

   // divider masks
   localparam logic [PRESC_W-1:0] MED_MASK_MAX = 13'h003F;
   localparam logic [1:0] MED_SEL_MAX = 2'h3;
   localparam logic [2:0] SUB_MASK_2 = 3'h1;
   localparam logic [2:0] SUB_MASK_4 = 3'h3;
   localparam logic [2:0] SUB_MASK_8 = 3'h7;

   typedef enum logic [2:0] {
      MODE_ACT_HI,
      MODE_ACT_MED,
      MODE_SUBACT,
      MODE_SLP_HI,
      MODE_SLP_MED,
      MODE_SUBSLP,
      MODE_WATCH,
      MODE_STANDBY
   } pmcs_mode_t;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_SLEEP,
      ST_SUBACTIVE,
      ST_SUBSLEEP,
      ST_WATCH,
      ST_STANDBY,
      ST_OSC_START,
      ST_OSC_WAIT
   } pmcs_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } pmcs_req_t;

   // wait length in system clock cycles for each wait select code
   function automatic logic [WAIT_W-1:0] pmcs_wait_cycles(input logic [2:0] sel);
      logic [WAIT_W-1:0] n;
      n = 13'h0400;
      unique case (sel)
         3'h0: n = 13'h1000;
         3'h1: n = 13'h0800;
         3'h2: n = 13'h0400;
         3'h3: n = 13'h0200;
         3'h4: n = 13'h0100;
         3'h5: n = 13'h0002;
         3'h6: n = 13'h0010;
         3'h7: n = 13'h0040;
      endcase
      return n;
   endfunction : pmcs_wait_cycles

endpackage : pmcs_pkg

// ---- rtl/pmcs_gate.sv ----
// per-module clock enable cell with its own halt bit
// assumes tick_i is a one-cycle enable pulse aligned to clk_i
`timescale 1ns/1ps
module pmcs_gate
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic halt_i,
   output logic en_o
);

   logic en_q;

   // halt takes effect on the next pulse boundary only
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         en_q <= 1'b0;
      end
      else
      begin
         en_q <= tick_i & ~halt_i;
      end
   end

   assign en_o = en_q;

endmodule : pmcs_gate

// ---- rtl/pmcs_top.sv ----
// power mode clock sequencer: mode machine, dividers, wake wait, registers
// assumes sleep_i and wake_i are one-cycle pulses from cpu and interrupt logic
`timescale 1ns/1ps
module pmcs_top
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire pmcs_pkg::pmcs_req_t bus_i,
   output logic [7:0] rdata_o,
   input wire logic sleep_i,
   input wire logic wake_i,
   input wire logic sub_tick_i,
   input wire logic osc_stable_i,
   output logic osc_run_o,
   output logic cpu_en_o,
   output logic [pmcs_pkg::NUM_MODULES-1:0] per_en_o,
   output logic [pmcs_pkg::PRESC_W-1:0] presc_o
);

   logic rst_meta_q;
   logic rst_n_q;
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [7:0] mstop_q;
   logic [7:0] rdata_q;
   pmcs_pkg::pmcs_state_t state_q;
   pmcs_pkg::pmcs_state_t state_d;
   logic [pmcs_pkg::PRESC_W-1:0] presc_q;
   logic [2:0] sub_cnt_q;
   logic [pmcs_pkg::WAIT_W-1:0] wait_q;
   logic [1:0] med_sel_q;
   logic [1:0] sub_sel_q;
   logic medium_q;
   logic osc_run_q;
   logic cpu_en_q;
   logic sys_gen;
   logic presc_wrap;
   logic sub_wrap;
   logic [pmcs_pkg::PRESC_W-1:0] med_mask;
   logic [2:0] sub_mask;
   logic med_tick;
   logic sub_div_tick;
   logic sys_tick;
   logic cpu_tick;
   logic per_tick;
   logic [2:0] wait_sel;
   pmcs_pkg::pmcs_mode_t mode;

   // reset release through two flops
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   assign wait_sel = ctrl1_q[pmcs_pkg::WAIT_SEL_HI:pmcs_pkg::WAIT_SEL_LO];

   // register writes
   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ctrl1_q <= pmcs_pkg::CTRL1_RST;
         ctrl2_q <= pmcs_pkg::CTRL2_RST;
         mstop_q <= pmcs_pkg::MSTOP_RST;
      end
      else if (bus_i.we)
      begin
         unique case (bus_i.addr)
            pmcs_pkg::ADDR_CTRL1: ctrl1_q <= bus_i.wdata;
            pmcs_pkg::ADDR_CTRL2: ctrl2_q <= bus_i.wdata;
            pmcs_pkg::ADDR_MSTOP: mstop_q <= bus_i.wdata;
            default: ;
         endcase
      end
   end

   // current documented mode, reported in status
   always_comb
   begin
      mode = pmcs_pkg::MODE_ACT_HI;
      unique case (state_q)
         pmcs_pkg::ST_ACTIVE: mode = medium_q ? pmcs_pkg::MODE_ACT_MED : pmcs_pkg::MODE_ACT_HI;
         pmcs_pkg::ST_SLEEP: mode = medium_q ? pmcs_pkg::MODE_SLP_MED : pmcs_pkg::MODE_SLP_HI;
         pmcs_pkg::ST_SUBACTIVE: mode = pmcs_pkg::MODE_SUBACT;
         pmcs_pkg::ST_SUBSLEEP: mode = pmcs_pkg::MODE_SUBSLP;
         pmcs_pkg::ST_WATCH: mode = pmcs_pkg::MODE_WATCH;
         pmcs_pkg::ST_STANDBY: mode = pmcs_pkg::MODE_STANDBY;
         pmcs_pkg::ST_OSC_START: mode = pmcs_pkg::MODE_STANDBY;
         pmcs_pkg::ST_OSC_WAIT: mode = medium_q ? pmcs_pkg::MODE_ACT_MED : pmcs_pkg::MODE_ACT_HI;
      endcase
   end

   // read data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         rdata_q <= 8'h00;
      end
      else if (bus_i.re)
      begin
         unique case (bus_i.addr)
            pmcs_pkg::ADDR_CTRL1: rdata_q <= ctrl1_q;
            pmcs_pkg::ADDR_CTRL2: rdata_q <= ctrl2_q;
            pmcs_pkg::ADDR_MSTOP: rdata_q <= mstop_q;
            pmcs_pkg::ADDR_STATUS: rdata_q <= {1'b0, state_q, 1'b0, mode};
            default: rdata_q <= 8'h00;
         endcase
      end
      else
      begin
         rdata_q <= 8'h00;
      end
   end

   // next mode on sleep or wake
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         pmcs_pkg::ST_ACTIVE:
         begin
            if (sleep_i)
            begin
               if (!ctrl1_q[pmcs_pkg::DEEP_SLEEP_BIT])
               begin
                  state_d = pmcs_pkg::ST_SLEEP;
               end
               else if (ctrl2_q[pmcs_pkg::WATCH_KEEP_BIT])
               begin
                  state_d = pmcs_pkg::ST_WATCH;
               end
               else
               begin
                  state_d = pmcs_pkg::ST_STANDBY;
               end
            end
         end
         pmcs_pkg::ST_SLEEP:
         begin
            if (wake_i)
            begin
               state_d = pmcs_pkg::ST_ACTIVE;
            end
         end
         pmcs_pkg::ST_SUBACTIVE:
         begin
            if (sleep_i)
            begin
               if (!ctrl1_q[pmcs_pkg::DEEP_SLEEP_BIT])
               begin
                  state_d = pmcs_pkg::ST_SUBSLEEP;
               end
               else if (!ctrl1_q[pmcs_pkg::WAKE_CLK_BIT])
               begin
                  state_d = pmcs_pkg::ST_OSC_START;
               end
               else
               begin
                  state_d = pmcs_pkg::ST_WATCH;
               end
            end
         end
         pmcs_pkg::ST_SUBSLEEP:
         begin
            if (wake_i)
            begin
               state_d = pmcs_pkg::ST_SUBACTIVE;
            end
         end
         pmcs_pkg::ST_WATCH:
         begin
            if (wake_i)
            begin
               state_d = ctrl1_q[pmcs_pkg::WAKE_CLK_BIT] ? pmcs_pkg::ST_SUBACTIVE : pmcs_pkg::ST_OSC_START;
            end
         end
         pmcs_pkg::ST_STANDBY:
         begin
            if (wake_i)
            begin
               state_d = pmcs_pkg::ST_OSC_START;
            end
         end
         pmcs_pkg::ST_OSC_START:
         begin
            if (osc_stable_i)
            begin
               state_d = pmcs_pkg::ST_OSC_WAIT;
            end
         end
         pmcs_pkg::ST_OSC_WAIT:
         begin
            if (wait_q == 13'h0001)
            begin
               state_d = pmcs_pkg::ST_ACTIVE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q <= pmcs_pkg::ST_ACTIVE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // wait counter, preset on system clock start
   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         wait_q <= 13'h0000;
      end
      else if (state_q == pmcs_pkg::ST_OSC_START && osc_stable_i)
      begin
         wait_q <= pmcs_pkg::pmcs_wait_cycles(wait_sel);
      end
      else if (state_q == pmcs_pkg::ST_OSC_WAIT && wait_q != 13'h0000)
      begin
         wait_q <= wait_q - 13'h0001;
      end
   end

   // system clock generator runs in active, sleep and the wake wait only, not while the oscillator starts
   assign sys_gen = (state_q == pmcs_pkg::ST_ACTIVE) || (state_q == pmcs_pkg::ST_SLEEP)
                    || (state_q == pmcs_pkg::ST_OSC_WAIT);

   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         osc_run_q <= 1'b1;
      end
      else
      begin
         osc_run_q <= sys_gen || (state_d == pmcs_pkg::ST_OSC_START) || (state_d == pmcs_pkg::ST_OSC_WAIT);
      end
   end

   // prescaler counts only while the system clock is generated
   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         presc_q <= 13'h0000;
      end
      else if (!sys_gen)
      begin
         presc_q <= 13'h0000;
      end
      else
      begin
         presc_q <= presc_q + 13'h0001;
      end
   end

   // subclock divider
   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         sub_cnt_q <= 3'h0;
      end
      else if (sub_tick_i)
      begin
         sub_cnt_q <= sub_cnt_q + 3'h1;
      end
   end

   assign presc_wrap = (presc_q & pmcs_pkg::MED_MASK_MAX) == pmcs_pkg::MED_MASK_MAX;
   assign sub_wrap = sub_tick_i && (sub_cnt_q == pmcs_pkg::SUB_MASK_8);

   // divider selects follow the registers at a full divider wrap; the medium select also follows while the system clock is stopped
   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         med_sel_q <= pmcs_pkg::CTRL1_RST[pmcs_pkg::MED_DIV_HI:pmcs_pkg::MED_DIV_LO];
         medium_q <= pmcs_pkg::CTRL2_RST[pmcs_pkg::MEDIUM_BIT];
      end
      else if (presc_wrap || !sys_gen)
      begin
         med_sel_q <= ctrl1_q[pmcs_pkg::MED_DIV_HI:pmcs_pkg::MED_DIV_LO];
         medium_q <= ctrl2_q[pmcs_pkg::MEDIUM_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         sub_sel_q <= pmcs_pkg::CTRL2_RST[pmcs_pkg::SUB_DIV_HI:pmcs_pkg::SUB_DIV_LO];
      end
      else if (sub_wrap)
      begin
         sub_sel_q <= ctrl2_q[pmcs_pkg::SUB_DIV_HI:pmcs_pkg::SUB_DIV_LO];
      end
   end

   // medium speed tick every 8, 16, 32 or 64 oscillator cycles
   assign med_mask = pmcs_pkg::MED_MASK_MAX >> (pmcs_pkg::MED_SEL_MAX - med_sel_q);
   assign med_tick = (presc_q & med_mask) == med_mask;

   // subclock tick every 2, 4 or 8 subclock periods
   always_comb
   begin
      sub_mask = pmcs_pkg::SUB_MASK_8;
      unique case (sub_sel_q)
         2'h0: sub_mask = pmcs_pkg::SUB_MASK_2;
         2'h1: sub_mask = pmcs_pkg::SUB_MASK_4;
         2'h2: sub_mask = pmcs_pkg::SUB_MASK_8;
         2'h3: sub_mask = pmcs_pkg::SUB_MASK_8;
      endcase
   end

   assign sub_div_tick = sub_tick_i && ((sub_cnt_q & sub_mask) == sub_mask);
   assign sys_tick = medium_q ? med_tick : 1'b1;

   // clock source per mode; wait and start phases give no pulses
   always_comb
   begin
      cpu_tick = 1'b0;
      per_tick = 1'b0;
      unique case (state_q)
         pmcs_pkg::ST_ACTIVE:
         begin
            cpu_tick = sys_tick;
            per_tick = sys_tick;
         end
         pmcs_pkg::ST_SLEEP:
         begin
            per_tick = sys_tick;
         end
         pmcs_pkg::ST_SUBACTIVE:
         begin
            cpu_tick = sub_div_tick;
            per_tick = sub_div_tick;
         end
         pmcs_pkg::ST_SUBSLEEP:
         begin
            per_tick = sub_div_tick;
         end
         pmcs_pkg::ST_WATCH:
         begin
            per_tick = sub_tick_i;
         end
         pmcs_pkg::ST_STANDBY:
         begin
            per_tick = 1'b0;
         end
         pmcs_pkg::ST_OSC_START:
         begin
            per_tick = 1'b0;
         end
         pmcs_pkg::ST_OSC_WAIT:
         begin
            per_tick = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         cpu_en_q <= 1'b0;
      end
      else
      begin
         cpu_en_q <= cpu_tick;
      end
   end

   // one gate per peripheral with its own halt bit
   for (genvar g = 0; g < pmcs_pkg::NUM_MODULES; g++)
   begin : g_gate
      pmcs_gate u_gate
      (
         .clk_i(clk_i),
         .rst_n_i(rst_n_q),
         .tick_i(per_tick),
         .halt_i(mstop_q[g]),
         .en_o(per_en_o[g])
      );
   end

   assign rdata_o = rdata_q;
   assign osc_run_o = osc_run_q;
   assign cpu_en_o = cpu_en_q;
   assign presc_o = presc_q;

endmodule : pmcs_top

// ---- dv/pmcs_far_model.sv ----
// far side model: subclock tick source and system oscillator start-up
// assumes osc_run_i comes from the sequencer; start delay set by the bench
`timescale 1ns/1ps
module pmcs_far_model
#(
   parameter int SUB_P = 4
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic osc_run_i,
   input wire logic [7:0] start_dly_i,
   output logic sub_tick_o,
   output logic osc_stable_o
);
   logic [7:0] sub_cnt_q;
   logic [7:0] start_cnt_q;
   // subclock never stopped, so every mode stays legal
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i) sub_cnt_q <= 8'h00;
      else if (sub_cnt_q == 8'(SUB_P - 1)) sub_cnt_q <= 8'h00;
      else sub_cnt_q <= sub_cnt_q + 8'h01;
   end
   assign sub_tick_o = nrst_i && (sub_cnt_q == 8'(SUB_P - 1));
   // start interval counted from oscillator enable
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i) start_cnt_q <= 8'h00;
      else if (!osc_run_i) start_cnt_q <= 8'h00;
      else if (start_cnt_q != 8'hFF) start_cnt_q <= start_cnt_q + 8'h01;
   end
   assign osc_stable_o = nrst_i && osc_run_i && (start_cnt_q >= start_dly_i);
endmodule : pmcs_far_model

// ---- dv/pmcs_top_assertions.sv ----
// checker for the sequencer top: enables, prescaler, wake wait, read port
// assumes a shadow of written controls is enough to know the requested mode
`timescale 1ns/1ps
module pmcs_top_chk
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire pmcs_pkg::pmcs_req_t bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic sleep_i,
   input wire logic wake_i,
   input wire logic sub_tick_i,
   input wire logic osc_stable_i,
   input wire logic osc_run_o,
   input wire logic cpu_en_o,
   input wire logic [pmcs_pkg::NUM_MODULES-1:0] per_en_o,
   input wire logic [pmcs_pkg::PRESC_W-1:0] presc_o
);
   localparam int WAKE_MAX = 4200;
   logic stable_q;
   logic [15:0] wake_cnt_q;
   logic [7:0] c1_q;
   logic [7:0] c2_q;
   logic [7:0] ms_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         c1_q <= pmcs_pkg::CTRL1_RST;
         c2_q <= pmcs_pkg::CTRL2_RST;
         ms_q <= pmcs_pkg::MSTOP_RST;
      end
      else if (bus_i.we)
      begin
         if (bus_i.addr == pmcs_pkg::ADDR_CTRL1) c1_q <= bus_i.wdata;
         if (bus_i.addr == pmcs_pkg::ADDR_CTRL2) c2_q <= bus_i.wdata;
         if (bus_i.addr == pmcs_pkg::ADDR_MSTOP) ms_q <= bus_i.wdata;
      end
   end
   // cycles since osc_stable_i rises with all peripheral enables low, cleared by a cpu pulse
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         stable_q <= 1'b0;
         wake_cnt_q <= 16'h0000;
      end
      else
      begin
         stable_q <= osc_stable_i;
         if (cpu_en_o)
         begin
            wake_cnt_q <= 16'h0000;
         end
         else if (osc_stable_i && !stable_q && per_en_o == 8'h00)
         begin
            wake_cnt_q <= 16'h0001;
         end
         else if (wake_cnt_q != 16'h0000 && wake_cnt_q != 16'hFFFF)
         begin
            wake_cnt_q <= wake_cnt_q + 16'h0001;
         end
      end
   end
   sequence s_wake_start;
      cpu_en_o == 1'b0 && per_en_o == 8'h00 && $rose(osc_stable_i);
   endsequence
   sequence s_idle2;
      (cpu_en_o == 1'b0 && per_en_o == 8'h00) [*2];
   endsequence
   sequence s_deep_req;
      sleep_i && osc_run_o && cpu_en_o && c1_q[7] && !c2_q[3];
   endsequence
   sequence s_all_off;
      (!cpu_en_o && per_en_o == 8'h00 && presc_o == 13'h0000) [*2];
   endsequence
   sequence s_med_rise;
      cpu_en_o && !$past(cpu_en_o) && c2_q[2] && osc_run_o;
   endsequence
   chk_rdata_idle: assert property (!$past(bus_i.re) |-> rdata_o == 8'h00)
      else $error("read data outside its cycle");
   chk_presc_clear: assert property (!osc_run_o && !$past(osc_run_o) |-> presc_o == 13'h0000)
      else $error("prescaler running with oscillator off");
   chk_wait_idle: assert property (s_wake_start |-> ##1 s_idle2)
      else $error("clocks released during wake wait");
   chk_wake_bound: assert property (wake_cnt_q <= WAKE_MAX)
      else $error("wake wait never ended");
   chk_module_halt: assert property ((per_en_o & ms_q & $past(ms_q)) == 8'h00)
      else $error("halted module clock enabled");
   chk_sleep_stop: assert property (sleep_i && osc_run_o && cpu_en_o && !c1_q[7] |-> ##2 (!cpu_en_o) [*3])
      else $error("cpu clock running in sleep");
   chk_standby_halt: assert property (s_deep_req |-> ##3 s_all_off)
      else $error("clock running in standby");
   chk_med_period: assert property (s_med_rise |=> (!cpu_en_o) [*7])
      else $error("medium speed pulse too early");
endmodule : pmcs_top_chk
bind pmcs_top pmcs_top_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .sleep_i(sleep_i), .wake_i(wake_i), .sub_tick_i(sub_tick_i), .osc_stable_i(osc_stable_i), .osc_run_o(osc_run_o),
   .cpu_en_o(cpu_en_o), .per_en_o(per_en_o), .presc_o(presc_o));

// ---- dv/tb_power_mode_clock_sequencer.sv ----
// testbench for the sequencer top: registers, modes, dividers, wake wait
// assumes the far side model supplies subclock ticks and oscillator start-up
`timescale 1ns/1ps
module tb_power_mode_clock_sequencer;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   pmcs_pkg::pmcs_req_t bus_i = '0;
   logic sleep_i = 1'b0;
   logic wake_i = 1'b0;
   logic sub_tick_i;
   logic osc_stable_i;
   logic [7:0] rdata_o;
   logic osc_run_o;
   logic cpu_en_o;
   logic [7:0] per_en_o;
   logic [pmcs_pkg::PRESC_W-1:0] presc_o;
   logic [7:0] dly = 8'h05;
   int n_mismatch = 0;
   int samples_checked = 0;
   int waits[8] = '{4096, 2048, 1024, 512, 256, 2, 16, 64};
   always #20 clk_i = ~clk_i;
   pmcs_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_o(rdata_o), .sleep_i(sleep_i),
      .wake_i(wake_i), .sub_tick_i(sub_tick_i), .osc_stable_i(osc_stable_i), .osc_run_o(osc_run_o),
      .cpu_en_o(cpu_en_o), .per_en_o(per_en_o), .presc_o(presc_o));
   pmcs_far_model far_u (.clk_i(clk_i), .nrst_i(nrst_i), .osc_run_i(osc_run_o), .start_dly_i(dly),
      .sub_tick_o(sub_tick_i), .osc_stable_o(osc_stable_i));
   task conclude;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_i.addr <= a;
      bus_i.wdata <= d;
      bus_i.we <= 1'b1;
      @(posedge clk_i);
      bus_i.we <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      bus_i.addr <= a;
      bus_i.re <= 1'b1;
      @(posedge clk_i);
      bus_i.re <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask : rd
   task pulse(input bit w);
      @(posedge clk_i);
      if (w) wake_i <= 1'b1;
      else sleep_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      sleep_i <= 1'b0;
      #1;
   endtask : pulse
   function automatic logic sig(input bit u);
      return u ? per_en_o[0] : cpu_en_o;
   endfunction : sig
   task meas(input bit u, input int exp);
      int c;
      c = 0;
      while (sig(u) !== 1'b1 && c < 300)
      begin
         cyc(1);
         c++;
      end
      cyc(1);
      c = 1;
      while (sig(u) !== 1'b1 && c < 300)
      begin
         cyc(1);
         c++;
      end
      chk(c, exp);
   endtask : meas
   task wake_tail(input int n);
      int c;
      c = 0;
      while (osc_stable_i !== 1'b1 && c < 300)
      begin
         cyc(1);
         c++;
      end
      chk(cpu_en_o, 1'b0);
      c = 0;
      while (cpu_en_o !== 1'b1 && c < 5000)
      begin
         cyc(1);
         c++;
      end
      chk(c, n + 2);
      rd(4'h3, 8'h00);
   endtask : wake_tail
   task t_regs;
      rd(4'h0, 8'h03);
      rd(4'h1, 8'h00);
      rd(4'h2, 8'h00);
      rd(4'h3, 8'h00);
      rd(4'h5, 8'h00);
      wr(4'h3, 8'hFF);
      rd(4'h3, 8'h00);
      wr(4'h0, 8'h53);
      rd(4'h0, 8'h53);
      wr(4'h0, 8'h03);
   endtask : t_regs
   task t_sleep;
      pulse(0);
      cyc(1);
      rd(4'h3, 8'h13);
      chk(cpu_en_o, 1'b0);
      pulse(1);
      cyc(1);
      rd(4'h3, 8'h00);
   endtask : t_sleep
   task t_mstop;
      wr(4'h2, 8'hA5);
      cyc(3);
      repeat (8)
      begin
         chk(per_en_o, 8'h5A);
         cyc(1);
      end
      wr(4'h2, 8'h00);
   endtask : t_mstop
   task t_medium;
      wr(4'h1, 8'h04);
      for (int k = 0; k < 4; k++)
      begin
         wr(4'h0, 8'(k));
         cyc(130);
         meas(0, 8 << k);
      end
      rd(4'h3, 8'h01);
      pulse(0);
      cyc(1);
      rd(4'h3, 8'h14);
      chk(cpu_en_o, 1'b0);
      meas(1, 64);
      pulse(1);
      cyc(1);
      rd(4'h3, 8'h01);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h03);
      cyc(130);
   endtask : t_medium
   task t_wake(input int code);
      dly <= 8'(6 + code * 3);
      wr(4'h0, {1'b1, 3'(code), 4'h3});
      pulse(0);
      cyc(1);
      rd(4'h3, 8'h57);
      chk({cpu_en_o, per_en_o}, 9'h000);
      chk(presc_o, 13'h0000);
      pulse(1);
      rd(4'h3, 8'h67);
      wake_tail(waits[code]);
   endtask : t_wake
   task t_sub;
      wr(4'h1, 8'h08);
      wr(4'h0, 8'hDB);
      pulse(0);
      cyc(1);
      rd(4'h3, 8'h46);
      chk(cpu_en_o, 1'b0);
      meas(1, 4);
      pulse(1);
      cyc(1);
      rd(4'h3, 8'h22);
      for (int k = 0; k < 3; k++)
      begin
         wr(4'h1, 8'(k));
         cyc(80);
         meas(0, 8 << k);
      end
      pulse(0);
      cyc(1);
      rd(4'h3, 8'h46);
      pulse(1);
      cyc(1);
      rd(4'h3, 8'h22);
      wr(4'h0, 8'h5B);
      pulse(0);
      cyc(1);
      rd(4'h3, 8'h35);
      meas(1, 32);
      pulse(1);
      cyc(1);
      rd(4'h3, 8'h22);
      wr(4'h0, 8'hD3);
      pulse(0);
      rd(4'h3, 8'h67);
      wake_tail(waits[5]);
      wr(4'h1, 8'h08);
      pulse(0);
      cyc(1);
      rd(4'h3, 8'h46);
      pulse(1);
      rd(4'h3, 8'h67);
      wake_tail(waits[5]);
   endtask : t_sub
   initial
   begin
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      cyc(6);
      t_regs;
      t_sleep;
      t_mstop;
      t_medium;
      for (int k = 0; k < 8; k++)
         t_wake(k);
      t_sub;
      conclude;
   end
   initial
   begin
      #(40 * 40000);
      n_mismatch++;
      conclude;
   end
endmodule : tb_power_mode_clock_sequencer
